// ### hw/isl_map.vh
`ifndef ISL_MAP_VH
`define ISL_MAP_VH
// Register byte addresses
`define ISL_ADDR_CTRL     8'h00
`define ISL_ADDR_ENABLE   8'h04
`define ISL_ADDR_FLAGS    8'h08
`define ISL_ADDR_EDGE     8'h0c
`define ISL_ADDR_SVC      8'h10
// Control register fields
`define ISL_CTRL_GIE      0
// Enable / flag bit positions
`define ISL_B_HALLGRP     0
`define ISL_B_EXT         1
`define ISL_B_CMP0        2
`define ISL_B_FILT        3
`define ISL_B_LVD         4
`define ISL_B_PROT        5
`define ISL_B_SER         6
`define ISL_B_EE          7
`define ISL_B_HALLA       8
`define ISL_B_HALLB       9
`define ISL_B_HALLC       10
// Edge select field positions, two bits each
`define ISL_E_HALL        0
`define ISL_E_EXT         2
`define ISL_E_CMP0        4
`define ISL_E_FILT        6
// Edge select encodings
`define ISL_EDGE_OFF      2'h0
`define ISL_EDGE_RISE     2'h1
`define ISL_EDGE_FALL     2'h2
`define ISL_EDGE_BOTH     2'h3
// Vector numbers, lowest wins
`define ISL_VEC_HALL      3'h0
`define ISL_VEC_EXT       3'h1
`define ISL_VEC_CMP0      3'h2
`define ISL_VEC_FILT      3'h3
`define ISL_VEC_LVD       3'h4
`define ISL_VEC_PROT      3'h5
`define ISL_VEC_SER       3'h6
`define ISL_VEC_EE        3'h7
// Reset values
`define ISL_RST_CTRL      32'h0000_0000
`define ISL_RST_ENABLE    32'h0000_0000
`define ISL_RST_EDGE      32'h0000_0000
`define ISL_NUM_SRC       8
`endif

// ### hw/isl_sync.v
`timescale 1ns/1ps
module isl_sync (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Asynchronous inputs
   input  wire [5:0] async_i,
   // Synchronised outputs
   output reg  [5:0] sync_o
);
   reg [5:0] meta_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 6'h00;
         sync_o <= 6'h00;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule // isl_sync

// ### hw/isl_edge_det.v
`timescale 1ns/1ps
`include "isl_map.vh"
module isl_edge_det (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Sampled level and selection
   input  wire       level_i,
   input  wire [1:0] sel_i,
   // Qualified edge pulse
   output wire       hit_o
);
   reg  prev_q;
   wire rise;
   wire fall;

   always @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= level_i;
      end
   end

   assign rise  = level_i & ~prev_q;
   assign fall  = ~level_i & prev_q;
   assign hit_o = ((sel_i == `ISL_EDGE_RISE) & rise) |
                  ((sel_i == `ISL_EDGE_FALL) & fall) |
                  ((sel_i == `ISL_EDGE_BOTH) & (rise | fall));
endmodule // isl_edge_det

// ### hw/isl_irq_source_logic.v
// Overview of operation
// - Enabled Hall group with free stack calls vector 0 on selected Hall edge.
// - Hall service clears global enable and group flag; channel flags stay.
// - Hall edge select gives rising, falling, both, or off.
// - Selected edge on external pin sets external flag.
// - External vector needs global enable, own enable, free stack, pending edge.
// - External service clears external flag and global enable.
// - External edge select gives rising, falling, both, or off.
// - Selected comparator 0 output edge sets comparator flag.
// - Comparator vector needs enables and free stack; service clears flag, global.
// - Selected edge on filtered pin sets filter flag.
// - Filter vector needs enables and free stack; service clears flag, global.
// - Filter edge select gives rising, falling, both, or off.
// - Low voltage sets flag; enabled call; service clears flag, global.
// - Protection signal sets flag; enabled call; service clears flag, global.
// - Any serial condition raises the serial request.
// - Serial service clears serial flag and global; status flags untouched.
// - EEPROM cycle end sets flag; enabled call needs global and free stack.
// - EEPROM service clears its flag and global enable.
// - Hall vector needs global, group and the channel enable.
// - Flags set and hold while disabled, for later service.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "isl_map.vh"
module isl_irq_source_logic (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Pins from outside the clock domain
   input  wire [2:0]  hall_filt_i,
   input  wire        ext_irq_pin_i,
   input  wire        filtered_irq_pin_i,
   input  wire        cmp0_out_i,
   // Internal events, same clock
   input  wire        low_volt_det_i,
   input  wire        motor_protect_signal_i,
   input  wire        ser_txd_empty_i,
   input  wire        ser_tx_idle_i,
   input  wire        ser_rx_trig_i,
   input  wire        ser_overrun_i,
   input  wire        ser_addr_det_i,
   input  wire        ser_wake_i,
   input  wire        eeprom_cycle_end_i,
   // Core sequencer
   input  wire        stack_full_i,
   input  wire        call_ack_i,
   output reg         call_req_o,
   output reg  [2:0]  call_vec_o
);
   reg  [31:0] ctrl_q;
   reg  [31:0] enable_q;
   reg  [31:0] edge_q;
   reg  [10:0] flags_q;
   reg  [10:0] flags_d;
   reg  [31:0] rdata;
   reg         gie_d;
   reg  [2:0]  pick;
   reg         any;
   wire [5:0]  pins;
   wire [2:0]  hall_hit;
   wire        ext_hit;
   wire        cmp_hit;
   wire        filt_hit;
   wire        ser_evt;
   wire        acc;
   wire        wr;
   wire [7:0]  pend;
   wire        svc;
   wire [10:0] clr_w;
   wire [7:0]  en;
   integer     i;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] val;
      input [3:0]  sel;
      begin
         merge = {sel[3] ? val[31:24] : old[31:24],
                  sel[2] ? val[23:16] : old[23:16],
                  sel[1] ? val[15:8]  : old[15:8],
                  sel[0] ? val[7:0]   : old[7:0]};
      end
   endfunction

   isl_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i ({cmp0_out_i, filtered_irq_pin_i, ext_irq_pin_i, hall_filt_i}),
      .sync_o  (pins)
   );

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_hall
         isl_edge_det u_hall (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .level_i (pins[g]),
            .sel_i   (edge_q[`ISL_E_HALL+1:`ISL_E_HALL]),
            .hit_o   (hall_hit[g])
         );
      end
   endgenerate

   isl_edge_det u_ext (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (pins[3]),
      .sel_i   (edge_q[`ISL_E_EXT+1:`ISL_E_EXT]),
      .hit_o   (ext_hit)
   );

   isl_edge_det u_filt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (pins[4]),
      .sel_i   (edge_q[`ISL_E_FILT+1:`ISL_E_FILT]),
      .hit_o   (filt_hit)
   );

   isl_edge_det u_cmp (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (pins[5]),
      .sel_i   (edge_q[`ISL_E_CMP0+1:`ISL_E_CMP0]),
      .hit_o   (cmp_hit)
   );

   assign ser_evt = ser_txd_empty_i | ser_tx_idle_i | ser_rx_trig_i |
                    ser_overrun_i | ser_addr_det_i | ser_wake_i;

   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr  = acc & wb_we_i;
   assign en  = enable_q[7:0];

   // Hall group pends only via an enabled channel flag
   assign pend[`ISL_VEC_HALL] = flags_q[`ISL_B_HALLGRP] &
                                (|(flags_q[10:8] & enable_q[10:8]));
   assign pend[7:1] = flags_q[7:1];

   // Priority pick among enabled pending requests
   always @* begin
      pick = 3'h0;
      any  = 1'b0;
      for (i = `ISL_NUM_SRC - 1; i >= 0; i = i - 1) begin
         if (pend[i] & en[i]) begin
            pick = i[2:0];
            any  = 1'b1;
         end
      end
   end

   assign svc   = call_req_o & call_ack_i;
   // Servicing clears the source flag; Hall channel flags are left alone
   assign clr_w = svc ? ({3'h0, 8'h01} << call_vec_o) : 11'h000;

   // Flag set and clear; set wins over clear
   always @* begin
      flags_d = flags_q;
      if (wr && wb_adr_i == `ISL_ADDR_FLAGS) begin
         flags_d = flags_q & ~(wb_dat_i[10:0] & {{3{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
      end
      flags_d = flags_d & ~clr_w;
      flags_d[`ISL_B_HALLA] = flags_d[`ISL_B_HALLA] | hall_hit[0];
      flags_d[`ISL_B_HALLB] = flags_d[`ISL_B_HALLB] | hall_hit[1];
      flags_d[`ISL_B_HALLC] = flags_d[`ISL_B_HALLC] | hall_hit[2];
      flags_d[`ISL_B_HALLGRP] = flags_d[`ISL_B_HALLGRP] | (|hall_hit);
      flags_d[`ISL_B_EXT]  = flags_d[`ISL_B_EXT]  | ext_hit;
      flags_d[`ISL_B_CMP0] = flags_d[`ISL_B_CMP0] | cmp_hit;
      flags_d[`ISL_B_FILT] = flags_d[`ISL_B_FILT] | filt_hit;
      flags_d[`ISL_B_LVD]  = flags_d[`ISL_B_LVD]  | low_volt_det_i;
      flags_d[`ISL_B_PROT] = flags_d[`ISL_B_PROT] | motor_protect_signal_i;
      flags_d[`ISL_B_SER]  = flags_d[`ISL_B_SER]  | ser_evt;
      flags_d[`ISL_B_EE]   = flags_d[`ISL_B_EE]   | eeprom_cycle_end_i;
   end

   // Global enable: servicing clears it over a software write
   always @* begin
      gie_d = ctrl_q[`ISL_CTRL_GIE];
      if (wr && wb_adr_i == `ISL_ADDR_CTRL && wb_sel_i[0]) begin
         gie_d = wb_dat_i[`ISL_CTRL_GIE];
      end
      if (svc) begin
         gie_d = 1'b0;
      end
   end

   always @* begin
      case (wb_adr_i)
         `ISL_ADDR_CTRL:   rdata = ctrl_q;
         `ISL_ADDR_ENABLE: rdata = enable_q;
         `ISL_ADDR_FLAGS:  rdata = {21'h0, flags_q};
         `ISL_ADDR_EDGE:   rdata = edge_q;
         `ISL_ADDR_SVC:    rdata = {27'h0, call_req_o, 1'b0, call_vec_o};
         default:          rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q     <= `ISL_RST_CTRL;
         enable_q   <= `ISL_RST_ENABLE;
         edge_q     <= `ISL_RST_EDGE;
         flags_q    <= 11'h000;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0000_0000;
         call_req_o <= 1'b0;
         call_vec_o <= 3'h0;
      end else begin
         wb_ack_o <= acc;
         if (acc) begin
            wb_dat_o <= rdata;
         end
         if (wr && wb_adr_i == `ISL_ADDR_ENABLE) begin
            enable_q <= merge(enable_q, wb_dat_i, wb_sel_i) & 32'h0000_07ff;
         end
         if (wr && wb_adr_i == `ISL_ADDR_EDGE) begin
            edge_q <= merge(edge_q, wb_dat_i, wb_sel_i) & 32'h0000_00ff;
         end
         ctrl_q  <= {31'h0, gie_d};
         flags_q <= flags_d;
         // Request held until the core takes it
         if (svc) begin
            call_req_o <= 1'b0;
         end else if (!call_req_o) begin
            if (any && ctrl_q[`ISL_CTRL_GIE] && !stack_full_i) begin
               call_req_o <= 1'b1;
               call_vec_o <= pick;
            end
         end
      end
   end
endmodule // isl_irq_source_logic

// ### tb/isl_core_model.sv
`timescale 1ns/1ps
module isl_core_model (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // Bench controls
   input  wire slow_i,
   input  wire full_i,
   // Call link
   input  wire call_req_i,
   output reg  call_ack_o,
   output wire stack_full_o
);
   reg wait_q;
   // Stack state straight from the bench
   assign stack_full_o = full_i;
   // Takes a call at once or after a pause
   always @(posedge clk_i) begin
      if (rst_i || !call_req_i || call_ack_o) begin
         call_ack_o <= 1'b0;
         wait_q <= 1'b0;
      end else if (!slow_i || wait_q) begin
         call_ack_o <= 1'b1;
      end else begin
         wait_q <= 1'b1;
      end
   end
endmodule // isl_core_model

// ### tb/isl_chk_sva.sv
`timescale 1ns/1ps
module isl_chk (
   // Clock and reset
   input wire       clk_i,
   input wire       rst_i,
   // Bus handshake
   input wire       wb_cyc_i,
   input wire       wb_stb_i,
   input wire       wb_ack_o,
   // Call link
   input wire       stack_full_i,
   input wire       call_ack_i,
   input wire       call_req_o,
   input wire [2:0] call_vec_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_serviced;
      call_req_o && call_ack_i;
   endsequence
   chk_ack_next: assert property (s_take |=> wb_ack_o)
      else $error("bus ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held");
   chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("bus ack without request");
   chk_req_hold: assert property (call_req_o && !call_ack_i |=> call_req_o && $stable(call_vec_o))
      else $error("call dropped or vector moved");
   chk_req_done: assert property (s_serviced |=> !call_req_o [*2])
      else $error("call not retired after service");
   chk_full_block: assert property ($rose(call_req_o) |-> !$past(stack_full_i))
      else $error("call raised with stack full");
   chk_req_drop: assert property ($fell(call_req_o) |-> $past(call_ack_i))
      else $error("call withdrawn unserved");
   chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !call_req_o && !wb_ack_o)
      else $error("outputs active in reset");
endmodule // isl_chk
bind isl_irq_source_logic isl_chk u_chk (
   .clk_i       (clk_i),
   .rst_i       (rst_i),
   .wb_cyc_i    (wb_cyc_i),
   .wb_stb_i    (wb_stb_i),
   .wb_ack_o    (wb_ack_o),
   .stack_full_i(stack_full_i),
   .call_ack_i  (call_ack_i),
   .call_req_o  (call_req_o),
   .call_vec_o  (call_vec_o)
);

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        clk_i, rst_i, req, we, slow, full;
   logic [7:0]  adr;
   logic [31:0] wdat, rq;
   logic [5:0]  pins; // Pins driven only as inputs
   logic [8:0]  ev;
   wire  [31:0] dat_o;
   wire  [2:0]  vec;
   wire         ack, sfull, cack, creq;
   integer      bad_count, tests_run, cyc_n, s, m;
   logic [31:0] fm [4] = '{32'h101, 32'h2, 32'h4, 32'h8};
   integer      pb [4] = '{0, 3, 5, 4};
   isl_irq_source_logic uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .hall_filt_i(pins[2:0]), .ext_irq_pin_i(pins[3]),
      .filtered_irq_pin_i(pins[4]), .cmp0_out_i(pins[5]), .low_volt_det_i(ev[0]),
      .motor_protect_signal_i(ev[1]), .ser_txd_empty_i(ev[2]), .ser_tx_idle_i(ev[3]),
      .ser_rx_trig_i(ev[4]), .ser_overrun_i(ev[5]), .ser_addr_det_i(ev[6]),
      .ser_wake_i(ev[7]), .eeprom_cycle_end_i(ev[8]), .stack_full_i(sfull),
      .call_ack_i(cack), .call_req_o(creq), .call_vec_o(vec));
   isl_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .full_i(full),
      .call_req_i(creq), .call_ack_o(cack), .stack_full_o(sfull));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         bad_count = bad_count + 1;
         give_verdict;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n = n + 1;
      end
      chk({31'h0, ack}, 32'h1);
      rq = dat_o;
      req <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rq, e);
   endtask
   task automatic pulse(input logic [8:0] e);
      ev <= e;
      @(posedge clk_i);
      ev <= 9'h0;
      @(posedge clk_i);
   endtask
   task automatic serve(input logic [2:0] v);
      integer n;
      n = 0;
      while (!(creq === 1'b1 && cack === 1'b1) && n < 40) begin
         @(posedge clk_i);
         n = n + 1;
      end
      chk({28'h0, creq, vec}, {28'h0, 1'b1, v});
      @(posedge clk_i);
   endtask
   initial begin
      bad_count = 0;
      tests_run = 0;
      cyc_n = 0;
      rst_i = 1'b1;
      {req, we, slow, full, adr, wdat, pins, ev} = '0;
      tick(16);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (s = 0; s < 5; s = s + 1) rdc(8'(s * 4), 32'h0);
      wb(1'b1, 8'h20, 32'hffff_ffff);
      rdc(8'h20, 32'h0);
      pulse(9'h103);
      rdc(8'h08, 32'hb0);
      wb(1'b1, 8'h04, 32'hb0);
      wb(1'b1, 8'h00, 32'h1);
      serve(3'h4);
      rdc(8'h00, 32'h0);
      rdc(8'h08, 32'ha0);
      wb(1'b1, 8'h00, 32'h1);
      serve(3'h5);
      wb(1'b1, 8'h00, 32'h1);
      serve(3'h7);
      rdc(8'h08, 32'h0);
      full <= 1'b1;
      slow <= 1'b1;
      pulse(9'h001);
      wb(1'b1, 8'h00, 32'h1);
      tick(8);
      chk({31'h0, creq}, 32'h0);
      full <= 1'b0;
      serve(3'h4);
      slow <= 1'b0;
      for (s = 0; s < 4; s = s + 1) begin
         for (m = 0; m < 4; m = m + 1) begin
            wb(1'b1, 8'h0c, 32'(m) << (2 * s));
            wb(1'b1, 8'h08, 32'h7ff);
            pins[pb[s]] <= 1'b1;
            tick(6);
            rdc(8'h08, m[0] ? fm[s] : 32'h0);
            wb(1'b1, 8'h08, 32'h7ff);
            pins[pb[s]] <= 1'b0;
            tick(6);
            rdc(8'h08, m[1] ? fm[s] : 32'h0);
         end
      end
      wb(1'b1, 8'h0c, 32'hff);
      wb(1'b1, 8'h08, 32'h7ff);
      wb(1'b1, 8'h04, 32'h1);
      pins[0] <= 1'b1;
      tick(6);
      wb(1'b1, 8'h00, 32'h1);
      tick(6);
      chk({31'h0, creq}, 32'h0);
      wb(1'b1, 8'h04, 32'h10f);
      serve(3'h0);
      rdc(8'h08, 32'h100);
      rdc(8'h00, 32'h0);
      for (s = 0; s < 4; s = s + 1) begin
         if (s > 0) begin
            pins[pb[s]] <= 1'b1;
            tick(6);
            wb(1'b1, 8'h00, 32'h1);
            serve(3'(s));
            rdc(8'h08, 32'h0);
         end
         pins[pb[s]] <= 1'b0;
         tick(6);
         wb(1'b1, 8'h08, 32'h7ff);
      end
      wb(1'b1, 8'h04, 32'h40);
      for (s = 0; s < 6; s = s + 1) begin
         pulse(9'(4 << s));
         wb(1'b1, 8'h00, 32'h1);
         serve(3'h6);
         rdc(8'h08, 32'h0);
      end
      give_verdict;
   end
endmodule // tb_top
